// file: rtl/sfpc_top.sv
// Four-bit synchronous presettable counter with Wishbone control access
module sfpc_top
    import sfpc_pkg::*;
#(
    parameter sfpc_pkg::sfpc_mod_t MODULUS     = sfpc_pkg::SFPC_MOD_DECADE,
    parameter sfpc_pkg::sfpc_clr_t CLEAR_STYLE = sfpc_pkg::SFPC_CLR_ASYNC
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Wishbone classic slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [sfpc_pkg::WB_AW-1:0]   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [sfpc_pkg::WB_DW-1:0]   wb_dat_i,
    output logic      [sfpc_pkg::WB_DW-1:0]   wb_dat_o,
    output logic                              wb_ack_o,
    // Counter controls from same-clock logic
    input  wire logic                         count_clock_i,
    input  wire logic                         load_enable_n_i,
    input  wire logic                         count_enable_parallel_i,
    input  wire logic                         count_enable_trickle_i,
    input  wire logic                         async_clear_n_i,
    input  wire logic                         sync_clear_n_i,
    input  wire logic [sfpc_pkg::CNT_W-1:0]   preset_data_in_i,
    // Counter outputs
    output logic      [sfpc_pkg::CNT_W-1:0]   count_out_o,
    output logic                              terminal_count_out_o
);
    import sfpc_pkg::*;

    // ----------------------------------------------------------------
    // Variant constants
    // ----------------------------------------------------------------
    localparam logic IS_DEC   = (MODULUS == SFPC_MOD_DECADE);
    localparam logic IS_ASYNC = (CLEAR_STYLE == SFPC_CLR_ASYNC);
    localparam logic [3:0] MAX_STATE = IS_DEC ? DEC_MAX : BIN_MAX;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [CNT_W-1:0]  count_ff;
    logic [15:0]       ctrl_ff;
    logic              step_ff;
    logic              ack_ff;
    logic [WB_DW-1:0]  rdat_ff;

    // Effective controls
    logic              ovr;
    logic              eff_load_n;
    logic              eff_cep;
    logic              eff_cet;
    logic              eff_clear_n;
    logic [CNT_W-1:0]  eff_data;
    logic              edge_en;
    logic              cnt_go;
    logic              wb_req;
    sfpc_act_t         act;

    // ----------------------------------------------------------------
    // Control source select
    // ----------------------------------------------------------------
    // Software override lets a processor drive a stage without pin logic
    assign ovr        = ctrl_ff[CTRL_OVR];
    assign eff_load_n = ovr ? ctrl_ff[CTRL_LOAD_N] : load_enable_n_i;
    assign eff_cep    = ovr ? ctrl_ff[CTRL_CEP] : count_enable_parallel_i;
    assign eff_cet    = ovr ? ctrl_ff[CTRL_CET] : count_enable_trickle_i;
    assign eff_data   = ovr ? ctrl_ff[CTRL_DATA_LSB +: CNT_W] : preset_data_in_i;

    // Only the clear of the built variant is looked at
    always_comb begin
        if (ovr) begin
            eff_clear_n = ctrl_ff[CTRL_CLR_N];
        end else if (IS_ASYNC) begin
            eff_clear_n = async_clear_n_i;
        end else begin
            eff_clear_n = sync_clear_n_i;
        end
    end

    // Counter edge: pin strobe or a software step
    assign edge_en = count_clock_i | step_ff;

    // Internal count enable is the AND of five terms
    assign cnt_go = edge_en && eff_clear_n && eff_load_n && eff_cep && eff_cet;

    // ----------------------------------------------------------------
    // Edge action decode
    // ----------------------------------------------------------------
    // Fixed priority: clear, load, count, hold
    always_comb begin
        if (!IS_ASYNC && !eff_clear_n) begin
            act = SFPC_ACT_CLEAR;
        end else if (!eff_load_n) begin
            act = SFPC_ACT_LOAD;
        end else if (eff_cep && eff_cet) begin
            act = SFPC_ACT_COUNT;
        end else begin
            act = SFPC_ACT_HOLD;
        end
    end

    // ----------------------------------------------------------------
    // Next state on a counting edge
    // ----------------------------------------------------------------
    // Illegal decade codes fold back within two counts; pairing 11->6,
    // 13->4 and 15->2 keeps the decode to a few product terms
    function automatic logic [CNT_W-1:0] sfpc_next(input logic [CNT_W-1:0] q, input logic dec);
        logic [CNT_W-1:0] r;
        r = q + CNT_ONE;
        if (dec) begin
            unique case (q)
                DEC_MAX: r = CNT_ZERO;
                4'hb:    r = 4'h6;
                4'hd:    r = 4'h4;
                4'hf:    r = 4'h2;
                default: r = q + CNT_ONE;
            endcase
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Count register
    // ----------------------------------------------------------------
    // Asynchronous clear also empties the flip-flops on every clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= CNT_ZERO;
        end else if (IS_ASYNC && !eff_clear_n) begin
            count_ff <= CNT_ZERO;
        end else if (edge_en) begin
            unique case (act)
                SFPC_ACT_CLEAR: count_ff <= CNT_ZERO;
                SFPC_ACT_LOAD:  count_ff <= eff_data;
                SFPC_ACT_COUNT: count_ff <= sfpc_next(count_ff, IS_DEC);
                SFPC_ACT_HOLD:  count_ff <= count_ff;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Mask gives the immediate clear without waiting for the clock
    assign count_out_o = (IS_ASYNC && !eff_clear_n) ? CNT_ZERO : count_ff;

    // Fully decoded; combinational so cascaded stages see it this cycle
    assign terminal_count_out_o = eff_cet && (count_out_o == MAX_STATE);

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;

    // One wait cycle; ack drops the cycle after it rose
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req;
        end
    end

    // Control register write, byte lanes 0 and 1 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wb_req && wb_we_i && wb_adr_i == ADDR_CTRL) begin
            if (wb_sel_i[0]) begin
                ctrl_ff[7:0] <= wb_dat_i[7:0];
                ctrl_ff[CTRL_STEP] <= 1'b0;
            end
            if (wb_sel_i[1]) begin
                ctrl_ff[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // Step bit is a one-shot edge, never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_ff <= 1'b0;
        end else begin
            step_ff <= wb_req && wb_we_i && wb_adr_i == ADDR_CTRL
                       && wb_sel_i[0] && wb_dat_i[CTRL_STEP];
        end
    end

    // Read data captured with the ack; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= '0;
        end else if (wb_req) begin
            rdat_ff <= '0;
            if (wb_adr_i == ADDR_CTRL) begin
                rdat_ff[15:0] <= ctrl_ff;
            end else if (wb_adr_i == ADDR_STAT) begin
                rdat_ff[CNT_W-1:0] <= count_out_o;
                rdat_ff[STAT_TC]    <= terminal_count_out_o;
                rdat_ff[STAT_DEC]   <= IS_DEC;
                rdat_ff[STAT_ASYNC] <= IS_ASYNC;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // No edge, no asynchronous clear: count must not move
    chk_edge_only: assert property (
        !edge_en && eff_clear_n |=> $stable(count_ff))
        else $error("count moved without a counter edge");

    chk_count_step: assert property (
        cnt_go && (count_ff < DEC_MAX || (!IS_DEC && count_ff != BIN_MAX))
        |=> count_ff == CNT_W'($past(count_ff) + CNT_ONE))
        else $error("count did not advance when enabled");

    chk_load_copy: assert property (
        edge_en && eff_clear_n && !eff_load_n |=> count_ff == $past(eff_data))
        else $error("load did not copy preset data");

    chk_hold_state: assert property (
        edge_en && eff_clear_n && eff_load_n && !(eff_cep && eff_cet)
        |=> count_ff == $past(count_ff))
        else $error("count changed while an enable was low");

    chk_tc_decode: assert property (
        terminal_count_out_o |-> eff_cet && count_out_o == MAX_STATE)
        else $error("terminal count outside maximum state");

    chk_dec_wrap: assert property (
        IS_DEC && cnt_go && count_ff == DEC_MAX |=> count_ff == CNT_ZERO)
        else $error("decade count did not wrap from nine");

    chk_illegal_tc: assert property (
        IS_DEC && count_out_o > DEC_MAX |-> !terminal_count_out_o)
        else $error("illegal decade code raised terminal count");

    chk_illegal_back: assert property (
        (IS_DEC && cnt_go && count_ff > DEC_MAX) ##1 cnt_go |=> count_ff <= DEC_MAX)
        else $error("decade count did not recover in two edges");

    chk_dec_bound: assert property (
        IS_DEC && cnt_go && count_ff <= DEC_MAX |=> count_ff <= DEC_MAX)
        else $error("decade count passed nine");

    chk_bin_wrap: assert property (
        !IS_DEC && cnt_go && count_ff == BIN_MAX |=> count_ff == CNT_ZERO)
        else $error("binary count did not wrap from fifteen");

    chk_async_clear: assert property (
        IS_ASYNC && !eff_clear_n |-> count_out_o == CNT_ZERO ##1 count_ff == CNT_ZERO)
        else $error("asynchronous clear did not force zero");

    chk_sync_clear: assert property (
        !IS_ASYNC && edge_en && !eff_clear_n |=> count_ff == CNT_ZERO)
        else $error("synchronous clear lost priority");

    chk_sync_wait: assert property (
        !IS_ASYNC && !edge_en && !eff_clear_n |=> $stable(count_ff))
        else $error("synchronous clear acted without an edge");

    chk_cascade_gate: assert property (
        !eff_cet |-> !terminal_count_out_o)
        else $error("terminal count high with trickle enable low");

    chk_bus_ack: assert property (
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");

    chk_tc_raise: assert property (
        eff_cet && count_out_o == MAX_STATE |-> terminal_count_out_o)
        else $error("terminal count missing at maximum state");

    chk_load_first: assert property (
        edge_en && eff_clear_n && !eff_load_n && eff_cep && eff_cet |=> count_ff == $past(eff_data))
        else $error("count took priority over load");

    chk_async_wins: assert property (
        IS_ASYNC && !eff_clear_n && edge_en && !eff_load_n |=> count_ff == CNT_ZERO)
        else $error("load overrode asynchronous clear");

    chk_sync_load: assert property (
        !IS_ASYNC && edge_en && !eff_clear_n && !eff_load_n |=> count_ff == CNT_ZERO)
        else $error("load overrode synchronous clear");

    // Register bus behaviour
    chk_step_pulse: assert property (
        step_ff |=> !step_ff)
        else $error("step strobe longer than one cycle");

    chk_unmapped_read: assert property (
        wb_req && !wb_we_i && wb_adr_i != ADDR_CTRL && wb_adr_i != ADDR_STAT |=> wb_dat_o == '0)
        else $error("unmapped read returned data");

    chk_stat_write: assert property (
        wb_req && wb_we_i && wb_adr_i != ADDR_CTRL |=> $stable(ctrl_ff))
        else $error("write outside control changed control");

    chk_ack_idle: assert property (
        !wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a bus cycle");

    chk_read_ctrl: assert property (
        wb_req && !wb_we_i && wb_adr_i == ADDR_CTRL |=> wb_dat_o[15:0] == $past(ctrl_ff))
        else $error("control read back wrong");

    // Main scenarios
    cov_wrap:     cover property (cnt_go && count_ff == MAX_STATE ##1 count_ff == CNT_ZERO);
    cov_sync_clr: cover property (!IS_ASYNC && edge_en && !eff_clear_n);
    cov_load:     cover property (edge_en && eff_clear_n && !eff_load_n);
    cov_tc_high:  cover property (terminal_count_out_o && cnt_go);
    cov_sw_step:  cover property (ovr && step_ff && cnt_go);

endmodule

// file: shared/sfpc_pkg.sv
// Constants and types for the presettable counter
package sfpc_pkg;

    // ----------------------------------------------------------------
    // Counter widths and states
    // ----------------------------------------------------------------
    localparam int          CNT_W    = 4;
    localparam logic [3:0]  CNT_ZERO = 4'h0;
    localparam logic [3:0]  CNT_ONE  = 4'h1;
    localparam logic [3:0]  DEC_MAX  = 4'h9;
    localparam logic [3:0]  BIN_MAX  = 4'hf;

    // ----------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int          WB_AW     = 4;
    localparam int          WB_DW     = 32;
    localparam logic [3:0]  ADDR_CTRL = 4'h0;
    localparam logic [3:0]  ADDR_STAT = 4'h4;

    // Control register fields
    localparam int          CTRL_OVR      = 0;
    localparam int          CTRL_LOAD_N   = 1;
    localparam int          CTRL_CEP      = 2;
    localparam int          CTRL_CET      = 3;
    localparam int          CTRL_CLR_N    = 4;
    localparam int          CTRL_STEP     = 5;
    localparam int          CTRL_DATA_LSB = 8;
    localparam logic [15:0] CTRL_RESET    = 16'h001e;

    // Status register fields
    localparam int          STAT_TC    = 4;
    localparam int          STAT_DEC   = 5;
    localparam int          STAT_ASYNC = 6;

    // ----------------------------------------------------------------
    // Variant selection and per-edge action
    // ----------------------------------------------------------------
    typedef enum logic { SFPC_MOD_DECADE, SFPC_MOD_BINARY } sfpc_mod_t;
    typedef enum logic { SFPC_CLR_ASYNC, SFPC_CLR_SYNC } sfpc_clr_t;
    typedef enum logic [1:0] { SFPC_ACT_CLEAR, SFPC_ACT_LOAD,
                               SFPC_ACT_COUNT, SFPC_ACT_HOLD } sfpc_act_t;

endpackage

// file: sim/sfpc_stage_model.sv
// Behavioural next cascade stage fed by the block's terminal count
module sfpc_stage_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Shared strobe and enables
    input  wire logic       strobe_i,
    input  wire logic       cep_i,
    input  wire logic       cet_i,
    // Stage count
    output logic      [3:0] count_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // Binary stage, advances only while the lower stage is at maximum
    // -------------------------------------------------------------
    // Trickle enable is the lower terminal count, no extra gating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 4'h0;
        end else if (strobe_i && cep_i && cet_i) begin
            count_o <= count_o + 4'h1;
        end
    end
endmodule

// file: sim/tb.sv
// Self-checking bench for the presettable counter, decade-async and binary-sync variants
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfpc_pkg::*;

    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]  wb_adr_i, wb_sel_i, preset_data_in_i, count_out_o, nxt_stage;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        count_clock_i, load_enable_n_i, count_enable_parallel_i;
    logic        count_enable_trickle_i, async_clear_n_i, terminal_count_out_o;
    logic        sync_clear_n_i, tc_b;
    logic [3:0]  count_b;
    int          bad_count, check_count;

    sfpc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_clock_i(count_clock_i),
        .load_enable_n_i(load_enable_n_i), .count_enable_parallel_i(count_enable_parallel_i),
        .count_enable_trickle_i(count_enable_trickle_i), .async_clear_n_i(async_clear_n_i),
        .sync_clear_n_i(sync_clear_n_i), .preset_data_in_i(preset_data_in_i), .count_out_o(count_out_o),
        .terminal_count_out_o(terminal_count_out_o));

    // Binary, synchronous-clear variant on the same inputs
    if (1) begin : g_bin
        sfpc_top #(.MODULUS(SFPC_MOD_BINARY), .CLEAR_STYLE(SFPC_CLR_SYNC)) u_dut (.clk_i(clk_i),
            .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
            .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
            .count_clock_i(count_clock_i), .load_enable_n_i(load_enable_n_i),
            .count_enable_parallel_i(count_enable_parallel_i), .count_enable_trickle_i(count_enable_trickle_i),
            .async_clear_n_i(async_clear_n_i), .sync_clear_n_i(sync_clear_n_i),
            .preset_data_in_i(preset_data_in_i), .count_out_o(count_b), .terminal_count_out_o(tc_b));
    end

    sfpc_stage_model u_stage (.clk_i(clk_i), .rst_i(rst_i), .strobe_i(count_clock_i),
        .cep_i(count_enable_parallel_i), .cet_i(terminal_count_out_o), .count_o(nxt_stage));

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One counter edge; controls held over the strobed cycle, result settled after
    task automatic cnt_edge(input logic ld_n, input logic cp, input logic ct, input logic [3:0] d);
        @(posedge clk_i);
        load_enable_n_i <= ld_n;
        count_enable_parallel_i <= cp;
        count_enable_trickle_i <= ct;
        preset_data_in_i <= d;
        count_clock_i <= 1'b1;
        @(posedge clk_i);
        count_clock_i <= 1'b0;
        #1;
    endtask

    // Classic single cycle, waits for ack with no bound of its own
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_regs();
        wb_xfer(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {16'h0, CTRL_RESET});
        wb_xfer(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        // Override: load 5 through the step bit, then read it back
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0531);
        repeat (3) @(posedge clk_i);
        wb_xfer(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_0065);
        wb_xfer(1'b1, ADDR_CTRL, {16'h0, CTRL_RESET});
        $display("test regs done");
    endtask

    task automatic t_count();
        logic [3:0] base;
        cnt_edge(1'b0, 1'b1, 1'b1, 4'h0);
        base = nxt_stage;
        for (int i = 1; i <= 10; i++) begin
            cnt_edge(1'b1, 1'b1, 1'b1, 4'h7);
            chk({28'h0, count_out_o}, i % 10);
            chk({31'h0, terminal_count_out_o}, (i % 10) == 9);
        end
        chk({28'h0, nxt_stage}, base + 4'h1);
        $display("test count done");
    endtask

    task automatic t_hold_load();
        cnt_edge(1'b0, 1'b0, 1'b0, 4'h9);
        chk({31'h0, terminal_count_out_o}, 32'h0);
        cnt_edge(1'b1, 1'b0, 1'b1, 4'h0);
        chk({28'h0, count_out_o}, 32'h9);
        cnt_edge(1'b1, 1'b1, 1'b0, 4'h0);
        chk({28'h0, count_out_o}, 32'h9);
        cnt_edge(1'b0, 1'b1, 1'b1, 4'h3);
        chk({28'h0, count_out_o}, 32'h3);
        @(posedge clk_i);
        #1;
        chk({28'h0, count_out_o}, 32'h3);
        $display("test hold and load done");
    endtask

    task automatic t_illegal();
        for (int d = 10; d <= 15; d++) begin
            cnt_edge(1'b0, 1'b1, 1'b1, d[3:0]);
            chk({28'h0, count_out_o}, d);
            chk({31'h0, terminal_count_out_o}, 32'h0);
            cnt_edge(1'b1, 1'b1, 1'b1, 4'h0);
            chk({31'h0, terminal_count_out_o}, 32'h0);
            cnt_edge(1'b1, 1'b1, 1'b1, 4'h0);
            chk({31'h0, count_out_o <= DEC_MAX}, 32'h1);
        end
        $display("test illegal codes done");
    endtask

    task automatic t_clear();
        cnt_edge(1'b0, 1'b1, 1'b1, 4'h6);
        @(posedge clk_i);
        async_clear_n_i <= 1'b0;
        #1;
        chk({28'h0, count_out_o}, 32'h0);
        cnt_edge(1'b0, 1'b1, 1'b1, 4'h7);
        chk({28'h0, count_out_o}, 32'h0);
        async_clear_n_i <= 1'b1;
        cnt_edge(1'b1, 1'b1, 1'b1, 4'h0);
        chk({28'h0, count_out_o}, 32'h1);
        $display("test clear done");
    endtask

    task automatic t_binary();
        cnt_edge(1'b0, 1'b1, 1'b1, 4'he);
        chk({28'h0, count_b}, 32'he);
        cnt_edge(1'b1, 1'b1, 1'b1, 4'h0);
        chk({31'h0, tc_b}, 32'h1);
        cnt_edge(1'b1, 1'b1, 1'b1, 4'h0);
        chk({28'h0, count_b}, 32'h0);
        cnt_edge(1'b0, 1'b1, 1'b1, 4'h7);
        @(posedge clk_i);
        sync_clear_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({28'h0, count_b}, 32'h7);
        cnt_edge(1'b0, 1'b1, 1'b1, 4'h3);
        chk({28'h0, count_b}, 32'h0);
        chk({28'h0, count_out_o}, 32'h3);
        sync_clear_n_i <= 1'b1;
        $display("test binary sync done");
    endtask

    // -------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // -------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, count_clock_i, count_enable_parallel_i} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, preset_data_in_i} = '0;
        {rst_i, load_enable_n_i, count_enable_trickle_i, async_clear_n_i, sync_clear_n_i} = 5'h1f;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_count();
        t_hold_load();
        t_illegal();
        t_clear();
        t_binary();
        give_verdict();
    end

    // Whole run is about 120 cycles; allow generous margin
    initial begin
        #(40 * 5000);
        bad_count++;
        give_verdict();
    end
endmodule
